// File: lsir_regs.sv
/*
  Link status and identification register bank, an AHB-Lite slave.
  Assumes the checker and line fault detectors run on clk; strap pins
  are asynchronous and are synchronised here.
*/
// Implementation choice: the AHB-Lite register port.
// How it works
// RULE1: pass flag reads 0 until test finishes.
// RULE2: pass flag becomes 1 on successful finish.
// RULE3: negative wire fault code, reset normal.
// RULE4: positive wire fault code, reset normal.
// RULE5: strap register shows live four input levels.
// RULE6: identity fields constant; writes everywhere ignored.
`timescale 1ns/100ps
`default_nettype none

module lsir_regs #(
  // Arbitrary identifier value.
  parameter logic [7:0] IDENT_VALUE = 8'h5a,
  // Arbitrary revision value.
  parameter logic [3:0] REVISION_VALUE = 4'h1,
  parameter logic CAPABLE = 1'b0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Checker status from the link logic.
  input wire logic checker_start,
  input wire logic checker_done_ok,
  // Line fault detector codes.
  input wire logic [1:0] neg_wire_fault_code,
  input wire logic [1:0] pos_wire_fault_code,
  // Strap pins, asynchronous.
  input wire logic cable_type_level,
  input wire logic cable_select_level,
  input wire logic ctrl_bus_select_level,
  input wire logic local_ctrl_chan_enable_level,
  // Live status for local use.
  output logic checker_pass_flag
);

  logic pass_q, pass_d;
  logic [1:0] neg_q, pos_q;
  logic [3:0] strap_s1_q, strap_s2_q;
  logic rd_q;
  logic [7:0] idx_q;
  logic [31:0] rdata_q;

  // Strap pins are asynchronous; only the first synchroniser stage reads them.
  wire logic [3:0] strap_raw = {cable_type_level, cable_select_level,
    ctrl_bus_select_level, local_ctrl_chan_enable_level};
  // A transfer is taken only in a ready address phase; IDLE and BUSY slots are ignored.
  wire logic xfer = hsel && hready && (htrans == lsir_pkg::HTRANS_NONSEQ
    || htrans == lsir_pkg::HTRANS_SEQ);
  wire logic rd_req = xfer && !hwrite;
  // Writes are taken and answered OKAY, but nothing in the bank stores them.
  wire logic wr_req = xfer && hwrite;
  // The register index sits above the byte lane bits of the word address.
  wire logic [7:0] req_idx = haddr[9:2];

  // One compare per location keeps the decode flat for the read checks below.
  function automatic logic idx_hit(input logic [7:0] a, input logic [7:0] b);
    idx_hit = (a == b);
  endfunction

  wire logic hit_status = idx_hit(req_idx, lsir_pkg::IDX_LINK_STATUS);
  wire logic hit_rsvd_a = idx_hit(req_idx, lsir_pkg::IDX_RSVD_A);
  wire logic hit_rsvd_b = idx_hit(req_idx, lsir_pkg::IDX_RSVD_B);
  wire logic hit_rsvd_c = idx_hit(req_idx, lsir_pkg::IDX_RSVD_C);
  wire logic hit_rsvd_d = idx_hit(req_idx, lsir_pkg::IDX_RSVD_D);
  wire logic hit_rsvd_e = idx_hit(req_idx, lsir_pkg::IDX_RSVD_E);
  wire logic hit_rsvd_f = idx_hit(req_idx, lsir_pkg::IDX_RSVD_F);
  wire logic hit_rsvd_g = idx_hit(req_idx, lsir_pkg::IDX_RSVD_G);
  wire logic hit_rsvd_h = idx_hit(req_idx, lsir_pkg::IDX_RSVD_H);
  wire logic hit_strap = idx_hit(req_idx, lsir_pkg::IDX_STRAP);
  wire logic hit_ident = idx_hit(req_idx, lsir_pkg::IDX_IDENT);
  wire logic hit_caprev = idx_hit(req_idx, lsir_pkg::IDX_CAPREV);
  // Every other index reads as zero.
  wire logic hit_any = hit_status || hit_rsvd_a || hit_rsvd_b || hit_rsvd_c || hit_rsvd_d
    || hit_rsvd_e || hit_rsvd_f || hit_rsvd_g || hit_rsvd_h || hit_strap || hit_ident
    || hit_caprev;

  // RULE1: cleared at start of a test.
  // RULE2: set on successful finish; finish wins over start.
  assign pass_d = checker_done_ok ? 1'b1 : (checker_start ? 1'b0 : pass_q);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pass_q <= 1'b0;
    end else begin
      pass_q <= pass_d;
    end
  end

  // RULE3: negative wire code, normal after reset.
  // RULE4: positive wire code, normal after reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      neg_q <= lsir_pkg::FAULT_NORMAL;
      pos_q <= lsir_pkg::FAULT_NORMAL;
    end else begin
      neg_q <= neg_wire_fault_code;
      pos_q <= pos_wire_fault_code;
    end
  end

  // RULE5: two-stage synchroniser on strap pins.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_s1_q <= 4'h0;
      strap_s2_q <= 4'h0;
    end else begin
      strap_s1_q <= strap_raw;
      strap_s2_q <= strap_s1_q;
    end
  end

  wire logic [7:0] status_byte = {pass_q, 3'h0, neg_q, pos_q};
  wire logic [7:0] strap_byte = {strap_s2_q, 4'h0};
  wire logic [7:0] caprev_byte = {3'h0, CAPABLE, REVISION_VALUE};

  // RULE6: only constants and live status are read; writes store nothing.
  function automatic logic [7:0] read_mux(input logic [7:0] idx,
    input logic [7:0] st, input logic [7:0] sp, input logic [7:0] cr);
    case (idx)
      lsir_pkg::IDX_LINK_STATUS: read_mux = st;
      lsir_pkg::IDX_RSVD_A: read_mux = lsir_pkg::RSVD_A_VAL;
      lsir_pkg::IDX_RSVD_B: read_mux = lsir_pkg::RSVD_B_VAL;
      lsir_pkg::IDX_RSVD_C: read_mux = lsir_pkg::RSVD_C_VAL;
      lsir_pkg::IDX_RSVD_D: read_mux = lsir_pkg::RSVD_D_VAL;
      lsir_pkg::IDX_RSVD_E: read_mux = lsir_pkg::RSVD_E_VAL;
      lsir_pkg::IDX_STRAP: read_mux = sp;
      lsir_pkg::IDX_IDENT: read_mux = IDENT_VALUE;
      lsir_pkg::IDX_CAPREV: read_mux = cr;
      default: read_mux = lsir_pkg::RSVD_ZERO;
    endcase
  endfunction

  // Address is latched in the address phase; read data is sampled at that same
  // address-phase edge, so the read reflects status at that edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= 1'b0;
      idx_q <= 8'h00;
    end else begin
      rd_q <= rd_req;
      idx_q <= req_idx;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= lsir_pkg::RDATA_ZERO;
    end else if (rd_req) begin
      rdata_q <= {24'h00_0000, read_mux(req_idx, status_byte, strap_byte, caprev_byte)};
    end
  end

  // Zero wait states: every transfer ends in its first data phase, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign checker_pass_flag = pass_q;

  // RULE1: flag low after a start without finish.
  pass_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
    checker_start && !checker_done_ok |=> !checker_pass_flag)
    else $error("pass flag not cleared by test start");
  // RULE2: flag high after successful finish.
  pass_set_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
    checker_done_ok |=> checker_pass_flag)
    else $error("pass flag not set by test finish");
  // RULE1: flag rises only on a finish.
  pass_cause_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
    $rose(checker_pass_flag) |-> $past(checker_done_ok))
    else $error("pass flag rose without finish");
  // RULE3: status read shows negative code.
  neg_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
    rd_req && req_idx == lsir_pkg::IDX_LINK_STATUS |=> hrdata[3:2] == $past(neg_q))
    else $error("negative fault code misread");
  // RULE4: status read shows positive code.
  pos_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
    rd_req && req_idx == lsir_pkg::IDX_LINK_STATUS |=> hrdata[1:0] == $past(pos_q))
    else $error("positive fault code misread");
  // RULE5: strap bit follows pin after two edges.
  strap_sync_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
    ##2 strap_s2_q == $past(strap_raw, 2))
    else $error("strap synchroniser latency wrong");
  // RULE5: strap read low nibble zero.
  strap_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
    rd_req && req_idx == lsir_pkg::IDX_STRAP |=> hrdata[7:0] == {$past(strap_s2_q), 4'h0})
    else $error("strap readback wrong");
  // RULE6: identifier constant.
  ident_const_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    rd_req && req_idx == lsir_pkg::IDX_IDENT |=> hrdata == {24'h00_0000, IDENT_VALUE})
    else $error("identifier not constant");
  // RULE6: revision constant.
  caprev_const_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    rd_req && req_idx == lsir_pkg::IDX_CAPREV |=> hrdata[7:0] == caprev_byte)
    else $error("capability revision wrong");

  // Pass flag: reset value, hold, and its place in the status byte.
  // RULE1: flag low while in reset.
  pass_reset_a: assert property (@(posedge clk) // RULE1
    !rst_b |=> !checker_pass_flag)
    else $error("pass flag not low in reset");
  // RULE1: flag holds without start or finish.
  pass_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
    !checker_done_ok && !checker_start |=> $stable(checker_pass_flag))
    else $error("pass flag changed without cause");
  // RULE2: status read shows pass flag.
  pass_field_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
    rd_req && hit_status |=> hrdata[lsir_pkg::PASS_BIT] == $past(checker_pass_flag))
    else $error("pass flag misread");

  // Wire fault codes: reset value, one-cycle tracking and the zero bits beside them.
  // RULE3: negative code normal in reset.
  neg_reset_a: assert property (@(posedge clk) // RULE3
    !rst_b |=> neg_q == lsir_pkg::FAULT_NORMAL)
    else $error("negative fault code reset wrong");
  // RULE4: positive code normal in reset.
  pos_reset_a: assert property (@(posedge clk) // RULE4
    !rst_b |=> pos_q == lsir_pkg::FAULT_NORMAL)
    else $error("positive fault code reset wrong");
  // RULE3: negative code tracks detector.
  neg_track_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
    $past(rst_b) |-> neg_q == $past(neg_wire_fault_code))
    else $error("negative fault code not tracked");
  // RULE4: positive code tracks detector.
  pos_track_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
    $past(rst_b) |-> pos_q == $past(pos_wire_fault_code))
    else $error("positive fault code not tracked");
  // RULE3: unused status bits read zero.
  status_rsvd_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
    rd_req && hit_status |=> hrdata[lsir_pkg::PASS_BIT - 1 -: 3] == 3'h0)
    else $error("status reserved bits not zero");

  // Strap readback: each pin level three edges late, low nibble zero.
  // RULE5: strap low nibble zero.
  strap_low_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
    rd_req && hit_strap |=> hrdata[lsir_pkg::LCC_EN_BIT - 1 -: 4] == 4'h0)
    else $error("strap low nibble not zero");
  // RULE5: cable type level read.
  cable_type_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
    rd_req && hit_strap |=> hrdata[lsir_pkg::CABLE_TYPE_BIT] == $past(cable_type_level, 3))
    else $error("cable type level misread");
  // RULE5: cable select level read.
  cable_sel_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
    rd_req && hit_strap |=> hrdata[lsir_pkg::CABLE_SEL_BIT] == $past(cable_select_level, 3))
    else $error("cable select level misread");
  // RULE5: bus select level read.
  bus_sel_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
    rd_req && hit_strap |=>
    hrdata[lsir_pkg::BUS_SEL_BIT] == $past(ctrl_bus_select_level, 3))
    else $error("bus select level misread");
  // RULE5: local channel enable level read.
  lcc_en_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
    rd_req && hit_strap |=>
    hrdata[lsir_pkg::LCC_EN_BIT] == $past(local_ctrl_chan_enable_level, 3))
    else $error("local channel enable level misread");

  // Fixed locations, unmapped reads and the bus answer.
  // RULE6: reserved location a fixed.
  rsvd_a_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    rd_req && hit_rsvd_a |=> hrdata == {24'h00_0000, lsir_pkg::RSVD_A_VAL})
    else $error("reserved location a wrong");
  // RULE6: reserved location b fixed.
  rsvd_b_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    rd_req && hit_rsvd_b |=> hrdata == {24'h00_0000, lsir_pkg::RSVD_B_VAL})
    else $error("reserved location b wrong");
  // RULE6: reserved location c fixed.
  rsvd_c_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    rd_req && hit_rsvd_c |=> hrdata == {24'h00_0000, lsir_pkg::RSVD_C_VAL})
    else $error("reserved location c wrong");
  // RULE6: reserved location d fixed.
  rsvd_d_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    rd_req && hit_rsvd_d |=> hrdata == {24'h00_0000, lsir_pkg::RSVD_D_VAL})
    else $error("reserved location d wrong");
  // RULE6: reserved location e fixed.
  rsvd_e_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    rd_req && hit_rsvd_e |=> hrdata == {24'h00_0000, lsir_pkg::RSVD_E_VAL})
    else $error("reserved location e wrong");
  // RULE6: reserved location f zero.
  rsvd_f_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    rd_req && hit_rsvd_f |=> hrdata == {24'h00_0000, lsir_pkg::RSVD_ZERO})
    else $error("reserved location f wrong");
  // RULE6: reserved location g zero.
  rsvd_g_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    rd_req && hit_rsvd_g |=> hrdata == {24'h00_0000, lsir_pkg::RSVD_ZERO})
    else $error("reserved location g wrong");
  // RULE6: reserved location h zero.
  rsvd_h_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    rd_req && hit_rsvd_h |=> hrdata == {24'h00_0000, lsir_pkg::RSVD_ZERO})
    else $error("reserved location h wrong");
  // RULE6: capability top bits zero.
  caprev_rsvd_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    rd_req && hit_caprev |=> hrdata[lsir_pkg::CAP_BIT + 3 -: 3] == 3'h0)
    else $error("capability reserved bits not zero");
  // RULE6: capability flag constant.
  cap_flag_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    rd_req && hit_caprev |=> hrdata[lsir_pkg::CAP_BIT] == CAPABLE)
    else $error("capability flag wrong");
  // RULE6: unmapped index reads zero.
  unmapped_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    rd_req && !hit_any |=> hrdata == lsir_pkg::RDATA_ZERO)
    else $error("unmapped read not zero");
  // RULE6: upper read bits always zero.
  upper_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    hrdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  // RULE6: read data holds between reads.
  rdata_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    !rd_req |=> $stable(hrdata))
    else $error("read data changed without read");
  // RULE6: every transfer answered OKAY.
  write_okay_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    xfer |-> hreadyout && !hresp)
    else $error("transfer not answered okay");

  pass_seen_c: cover property (@(posedge clk) disable iff (!rst_b)
    checker_start ##[1:20] checker_done_ok);
  fault_seen_c: cover property (@(posedge clk) disable iff (!rst_b)
    neg_q == lsir_pkg::FAULT_OPEN);
  write_seen_c: cover property (@(posedge clk) disable iff (!rst_b)
    (wr_req && hsize == lsir_pkg::HSIZE_WORD) ##1
    hwdata != lsir_pkg::RDATA_ZERO);
  strap_rd_c: cover property (@(posedge clk) disable iff (!rst_b)
    rd_req && req_idx == lsir_pkg::IDX_STRAP);
  rsvd_rd_c: cover property (@(posedge clk) disable iff (!rst_b)
    rd_req && hit_rsvd_e);

endmodule

`default_nettype wire

// File: lsir_pkg.sv
/*
  Package for the link status and identification register bank.
  Assumes a 32-bit AHB-Lite register bus with one word per register.
*/
`default_nettype none

package lsir_pkg;

  // Printed offsets are not multiples of four, so they are register indices.
  localparam logic [7:0] IDX_LINK_STATUS = 8'h14;
  localparam logic [7:0] IDX_RSVD_A = 8'h15;
  localparam logic [7:0] IDX_RSVD_B = 8'h16;
  localparam logic [7:0] IDX_RSVD_C = 8'h17;
  localparam logic [7:0] IDX_RSVD_D = 8'h18;
  localparam logic [7:0] IDX_RSVD_E = 8'h19;
  localparam logic [7:0] IDX_RSVD_F = 8'h1a;
  localparam logic [7:0] IDX_RSVD_G = 8'h1b;
  localparam logic [7:0] IDX_RSVD_H = 8'h1c;
  localparam logic [7:0] IDX_STRAP = 8'h1d;
  localparam logic [7:0] IDX_IDENT = 8'h1e;
  localparam logic [7:0] IDX_CAPREV = 8'h1f;

  // Reset and fixed read values of the reserved locations.
  localparam logic [7:0] RSVD_A_VAL = 8'h20;
  localparam logic [7:0] RSVD_B_VAL = 8'h30;
  localparam logic [7:0] RSVD_C_VAL = 8'h54;
  localparam logic [7:0] RSVD_D_VAL = 8'h30;
  localparam logic [7:0] RSVD_E_VAL = 8'hc8;
  localparam logic [7:0] RSVD_ZERO = 8'h00;

  // Link status field positions.
  localparam int PASS_BIT = 7;
  localparam int NEG_LSB = 2;
  localparam int POS_LSB = 0;

  // Wire fault codes.
  localparam logic [1:0] FAULT_SHORT_SUPPLY = 2'h0;
  localparam logic [1:0] FAULT_SHORT_GND = 2'h1;
  localparam logic [1:0] FAULT_NORMAL = 2'h2;
  localparam logic [1:0] FAULT_OPEN = 2'h3;

  // Strap readback positions.
  localparam int CABLE_TYPE_BIT = 7;
  localparam int CABLE_SEL_BIT = 6;
  localparam int BUS_SEL_BIT = 5;
  localparam int LCC_EN_BIT = 4;

  // Capability flag position.
  localparam int CAP_BIT = 4;

  // AHB-Lite encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage

`default_nettype wire

// File: tb_lsir_regs.sv
/*
  Self-checking testbench for the link status and identification register bank.
  Assumes the bank is the only AHB-Lite slave, so its hreadyout feeds hready.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_lsir_regs;
  // Arbitrary identity values handed to the bank.
  localparam logic [7:0] ID_V = 8'h3c;
  localparam logic [3:0] REV_V = 4'h6;
  logic clk, rst_b, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, neg, pos;
  logic [2:0] hsize;
  logic start, done, pass, ct, cs, bs, le;
  logic [7:0] r;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;

  assign hready = hreadyout;
  lsir_regs #(.IDENT_VALUE(ID_V), .REVISION_VALUE(REV_V), .CAPABLE(1'b1)) uut (.clk(clk),
    .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .checker_start(start), .checker_done_ok(done), .neg_wire_fault_code(neg),
    .pos_wire_fault_code(pos), .cable_type_level(ct), .cable_select_level(cs),
    .ctrl_bus_select_level(bs), .local_ctrl_chan_enable_level(le), .checker_pass_flag(pass));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // A hang is cut short well past the expected run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= lsir_pkg::HTRANS_NONSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
    chk({30'h0, hresp, hreadyout}, 32'h1);
  endtask

  function automatic logic [31:0] stat_exp(input logic p, input logic [1:0] n, input logic [1:0] q);
    return {24'h0, p, 3'b000, n, q};
  endfunction

  function automatic logic [31:0] fix_exp(input logic [7:0] idx);
    case (idx)
      8'h15: return 32'h20;
      8'h16: return 32'h30;
      8'h17: return 32'h54;
      8'h18: return 32'h30;
      8'h19: return 32'hc8;
      8'h1e: return {24'h0, ID_V};
      8'h1f: return {24'h0, 3'b000, 1'b1, REV_V};
      default: return 32'h0;
    endcase
  endfunction

  initial begin
    {hwrite, htrans, haddr, hwdata, start, done, ct, cs, bs, le} = '0;
    hsel = 1'b1;
    hsize = lsir_pkg::HSIZE_WORD;
    neg = 2'h2;
    pos = 2'h2;
    rst_b = 1'b0;
    void'($urandom(32'hc6d0));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdchk(lsir_pkg::IDX_LINK_STATUS, 32'h0a);
    $display("test reset done");
    done <= 1'b1;
    start <= 1'b1;
    @(posedge clk);
    {done, start} <= 2'b00;
    @(posedge clk);
    chk({31'h0, pass}, 32'h1);
    rdchk(lsir_pkg::IDX_LINK_STATUS, 32'h8a);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    rdchk(lsir_pkg::IDX_LINK_STATUS, 32'h0a);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    @(posedge clk);
    chk({31'h0, pass}, 32'h1);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    chk({31'h0, pass}, 32'h0);
    $display("test pass flag done");
    for (int i = 0; i < 16; i++) begin
      neg <= i[3:2];
      pos <= i[1:0];
      @(posedge clk);
      rdchk(lsir_pkg::IDX_LINK_STATUS, stat_exp(1'b0, i[3:2], i[1:0]));
    end
    $display("test fault codes done");
    for (int i = 0; i < 24; i++) begin
      r = 8'($urandom);
      {ct, cs, bs, le} <= r[7:4];
      {neg, pos} <= r[3:0];
      repeat (4) @(posedge clk);
      rdchk(lsir_pkg::IDX_STRAP, {24'h0, r[7:4], 4'h0});
      rdchk(lsir_pkg::IDX_LINK_STATUS, stat_exp(1'b0, r[3:2], r[1:0]));
    end
    $display("test random straps done");
    {ct, cs, bs, le} <= 4'h0;
    repeat (4) @(posedge clk);
    for (logic [7:0] a = 8'h14; a <= 8'h21; a++) begin
      bus(1'b1, a, 32'hffff_ffff);
      if (a == 8'h14) rdchk(a, stat_exp(1'b0, r[3:2], r[1:0]));
      else rdchk(a, fix_exp(a));
    end
    $display("test fixed locations done");
    wrap_up();
  end
endmodule

`default_nettype wire
